// ### sfd_regs.svh
`ifndef SFD_REGS_SVH
`define SFD_REGS_SVH

// ---------------------------------------------------------------
// register space
// ---------------------------------------------------------------
`define SFD_SFR_PAGE 8'hFF
`define SFD_RAM_PAGE 8'hFE
`define SFD_SADDR_SFR_LIMIT 8'h20

// ---------------------------------------------------------------
// read/write byte registers, in storage index order
// ---------------------------------------------------------------
`define SFD_NUM_RW 28
`define SFD_ADDR_PORT0_DATA 16'hFF00
`define SFD_ADDR_PORT1_DATA 16'hFF01
`define SFD_ADDR_PORT2_DATA 16'hFF02
`define SFD_ADDR_PORT3_DATA 16'hFF03
`define SFD_ADDR_PORT4_DATA 16'hFF04
`define SFD_ADDR_PORT5_DATA 16'hFF05
`define SFD_ADDR_PORT0_DIR 16'hFF20
`define SFD_ADDR_PORT1_DIR 16'hFF21
`define SFD_ADDR_PORT2_DIR 16'hFF22
`define SFD_ADDR_PORT3_DIR 16'hFF23
`define SFD_ADDR_PORT4_DIR 16'hFF24
`define SFD_ADDR_PORT5_DIR 16'hFF25
`define SFD_ADDR_TIMER2_CLK_SEL 16'hFF42
`define SFD_ADDR_TIMER8_CONTROL 16'hFF53
`define SFD_ADDR_TIMER16_CONTROL 16'hFF5B
`define SFD_ADDR_ASYNC_MODE 16'hFF70
`define SFD_ADDR_SYNC_MODE 16'hFF72
`define SFD_ADDR_BAUD_CONTROL 16'hFF73
`define SFD_ADDR_IRQ_FLAGS_0 16'hFFE0
`define SFD_ADDR_IRQ_FLAGS_1 16'hFFE1
`define SFD_ADDR_IRQ_MASKS_0 16'hFFE4
`define SFD_ADDR_IRQ_MASKS_1 16'hFFE5
`define SFD_ADDR_EXT_IRQ_EDGE 16'hFFEC
`define SFD_ADDR_KEY_RETURN 16'hFFF5
`define SFD_ADDR_PULLUP_OPTION 16'hFFF7
`define SFD_ADDR_WATCHDOG_MODE 16'hFFF9
`define SFD_ADDR_OSC_SETTLE 16'hFFFA
`define SFD_ADDR_CPU_CLOCK 16'hFFFB

// storage indices of the interrupt flag bytes
`define SFD_IDX_IRQ_FLAGS_0 18
`define SFD_IDX_IRQ_FLAGS_1 19

// one bit per storage index: single-bit access allowed
`define SFD_RW_BIT_OK 28'h3BC8FFF

// ---------------------------------------------------------------
// other registers
// ---------------------------------------------------------------
`define SFD_ADDR_SERIAL_SHIFT 16'hFF10
`define SFD_ADDR_COMPARE16_LO 16'hFF16
`define SFD_ADDR_COMPARE16_HI 16'hFF17
`define SFD_ADDR_TIMER16_LO 16'hFF18
`define SFD_ADDR_TIMER16_HI 16'hFF19
`define SFD_ADDR_CAPTURE16_LO 16'hFF1A
`define SFD_ADDR_CAPTURE16_HI 16'hFF1B
`define SFD_ADDR_COMPARE8 16'hFF50
`define SFD_ADDR_TIMER8 16'hFF51
`define SFD_ADDR_ASYNC_STATUS 16'hFF71

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SFD_RST_ZERO8 8'h00
`define SFD_RST_ONES8 8'hFF
`define SFD_RST_OSC_SETTLE 8'h04
`define SFD_RST_CPU_CLOCK 8'h02
`define SFD_RST_SERIAL_SHIFT 8'hFF
`define SFD_RST_COMPARE16 16'hFFFF
`define SFD_RST_COMPARE8 8'h00

`endif

// ### sfd_pkg.sv
`default_nettype none

package sfd_pkg;

  // access width requested by the core
  typedef enum logic [1:0] {
    SFD_SIZE_BIT  = 2'h0,
    SFD_SIZE_BYTE = 2'h1,
    SFD_SIZE_WORD = 2'h3
  } sfd_size_t;

  // what an address resolves to inside the register page
  typedef enum logic [2:0] {
    SFD_CLS_NONE   = 3'h0,
    SFD_CLS_RW     = 3'h1,
    SFD_CLS_SERIAL = 3'h3,
    SFD_CLS_CMP16  = 3'h2,
    SFD_CLS_RO16   = 3'h6,
    SFD_CLS_CMP8   = 3'h7,
    SFD_CLS_RO8    = 3'h5,
    SFD_CLS_STATUS = 3'h4
  } sfd_class_t;

endpackage

`default_nettype wire

// ### sfd_space_decode.sv
// Functional notes
// R1 - decode all registers in page FF00H..FFFFH
// R2 - accept only each register's listed widths
// R3 - core gives even address for word access
// R4 - FF10H: write transmit shift, read receive
// R5 - compare16 FF16H/17H write-only, resets FFFFH
// R6 - timer16 count FF18H/19H read-only, resets 0000H
// R7 - capture16 FF1AH/1BH read-only, no reset value
// R8 - those three also take byte access
// R9 - their word access only via short direct
// R10 - six direction registers read/write, reset FFH
// R11 - irq flag bytes bit/byte access, reset 00H
// R12 - irq mask bytes bit/byte access, reset FFH
// R13 - oscillator settle select byte only, reset 04H
// R14 - cpu clock control byte only, reset 02H
// R15 - async status read-only, bit and byte
// R16 - compare8 write-only byte; timer8 read-only
// R17 - reset loads every listed after-reset value
// R18 - short operand below 20H maps to FFxxH
// R19 - unmapped page addresses: writes ignored, read zero
`timescale 1ns/1ps
`include "sfd_regs.svh"
`default_nettype none

module sfd_space_decode (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic short_i,
  input wire logic [1:0] size_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [7:0] rx_buffer_i,
  input wire logic [15:0] timer16_count_i,
  input wire logic [15:0] capture16_i,
  input wire logic [7:0] timer8_count_i,
  input wire logic [7:0] async_status_i,
  input wire logic [15:0] irq_set_i,
  output logic ack_o,
  output logic err_o,
  output logic [15:0] rdata_o,
  output logic [`SFD_NUM_RW*8-1:0] rw_regs_o,
  output logic [7:0] tx_shift_o,
  output logic tx_load_o,
  output logic [15:0] compare16_o,
  output logic compare16_wr_o,
  output logic [7:0] compare8_o,
  output logic compare8_wr_o
);

  localparam int NUM_RW = `SFD_NUM_RW;

  localparam logic [15:0] RW_ADDR [NUM_RW] = '{
    `SFD_ADDR_PORT0_DATA, `SFD_ADDR_PORT1_DATA, `SFD_ADDR_PORT2_DATA,
    `SFD_ADDR_PORT3_DATA, `SFD_ADDR_PORT4_DATA, `SFD_ADDR_PORT5_DATA,
    `SFD_ADDR_PORT0_DIR, `SFD_ADDR_PORT1_DIR, `SFD_ADDR_PORT2_DIR,
    `SFD_ADDR_PORT3_DIR, `SFD_ADDR_PORT4_DIR, `SFD_ADDR_PORT5_DIR,
    `SFD_ADDR_TIMER2_CLK_SEL, `SFD_ADDR_TIMER8_CONTROL,
    `SFD_ADDR_TIMER16_CONTROL, `SFD_ADDR_ASYNC_MODE,
    `SFD_ADDR_SYNC_MODE, `SFD_ADDR_BAUD_CONTROL,
    `SFD_ADDR_IRQ_FLAGS_0, `SFD_ADDR_IRQ_FLAGS_1,
    `SFD_ADDR_IRQ_MASKS_0, `SFD_ADDR_IRQ_MASKS_1,
    `SFD_ADDR_EXT_IRQ_EDGE, `SFD_ADDR_KEY_RETURN,
    `SFD_ADDR_PULLUP_OPTION, `SFD_ADDR_WATCHDOG_MODE,
    `SFD_ADDR_OSC_SETTLE, `SFD_ADDR_CPU_CLOCK
  };

  // after-reset values, same order as the addresses [R17]
  localparam logic [7:0] RW_RESET [NUM_RW] = '{
    `SFD_RST_ZERO8, `SFD_RST_ZERO8, `SFD_RST_ZERO8,
    `SFD_RST_ZERO8, `SFD_RST_ZERO8, `SFD_RST_ZERO8,
    `SFD_RST_ONES8, `SFD_RST_ONES8, `SFD_RST_ONES8,
    `SFD_RST_ONES8, `SFD_RST_ONES8, `SFD_RST_ONES8,
    `SFD_RST_ZERO8, `SFD_RST_ZERO8, `SFD_RST_ZERO8,
    `SFD_RST_ZERO8, `SFD_RST_ZERO8, `SFD_RST_ZERO8,
    `SFD_RST_ZERO8, `SFD_RST_ZERO8,
    `SFD_RST_ONES8, `SFD_RST_ONES8,
    `SFD_RST_ZERO8, `SFD_RST_ZERO8, `SFD_RST_ZERO8, `SFD_RST_ZERO8,
    `SFD_RST_OSC_SETTLE, `SFD_RST_CPU_CLOCK
  }; // [R10] [R11] [R12] [R13] [R14]

  localparam logic [NUM_RW-1:0] RW_BIT_OK = `SFD_RW_BIT_OK; // [R13] [R14]

  logic [7:0] rw_r [NUM_RW];
  logic [NUM_RW-1:0] rw_hit;
  logic [15:0] eff_addr;
  logic in_space;
  sfd_pkg::sfd_size_t size;
  sfd_pkg::sfd_class_t cls;
  logic legal;
  logic do_write;
  logic [7:0] rd_byte;
  logic [15:0] rd_word;
  logic [15:0] rdata_nxt;
  logic [7:0] tx_shift_r;
  logic [15:0] compare16_r;
  logic [7:0] compare8_r;

  assign size = sfd_pkg::sfd_size_t'(size_i);

  // ---------------------------------------------------------------
  // effective address
  // ---------------------------------------------------------------
  // a short operand at or above 20H lands in RAM, which is not ours
  always_comb
  begin
    eff_addr = addr_i;
    in_space = 1'h1;
    if (short_i)
    begin
      if (addr_i[7:0] < `SFD_SADDR_SFR_LIMIT)
        eff_addr = {`SFD_SFR_PAGE, addr_i[7:0]}; // [R18]
      else
      begin
        eff_addr = {`SFD_RAM_PAGE, addr_i[7:0]};
        in_space = 1'h0;
      end
    end
    else if (addr_i[15:8] != `SFD_SFR_PAGE)
      in_space = 1'h0; // [R1]
  end

  // ---------------------------------------------------------------
  // address decode and width check
  // ---------------------------------------------------------------
  always_comb
  begin
    cls = sfd_pkg::SFD_CLS_NONE;
    if (|rw_hit)
      cls = sfd_pkg::SFD_CLS_RW;
    else if (eff_addr == `SFD_ADDR_SERIAL_SHIFT)
      cls = sfd_pkg::SFD_CLS_SERIAL;
    else if (eff_addr == `SFD_ADDR_COMPARE16_LO ||
             eff_addr == `SFD_ADDR_COMPARE16_HI)
      cls = sfd_pkg::SFD_CLS_CMP16;
    else if (eff_addr == `SFD_ADDR_TIMER16_LO ||
             eff_addr == `SFD_ADDR_TIMER16_HI ||
             eff_addr == `SFD_ADDR_CAPTURE16_LO ||
             eff_addr == `SFD_ADDR_CAPTURE16_HI)
      cls = sfd_pkg::SFD_CLS_RO16;
    else if (eff_addr == `SFD_ADDR_COMPARE8)
      cls = sfd_pkg::SFD_CLS_CMP8;
    else if (eff_addr == `SFD_ADDR_TIMER8)
      cls = sfd_pkg::SFD_CLS_RO8;
    else if (eff_addr == `SFD_ADDR_ASYNC_STATUS)
      cls = sfd_pkg::SFD_CLS_STATUS;
  end

  // word access: short form only, even address only
  always_comb
  begin
    legal = 1'h0;
    case (cls)
      sfd_pkg::SFD_CLS_RW:
        legal = (size == sfd_pkg::SFD_SIZE_BYTE) ||
                (size == sfd_pkg::SFD_SIZE_BIT &&
                 |(rw_hit & RW_BIT_OK)); // [R2] [R11] [R12]
      sfd_pkg::SFD_CLS_SERIAL:
        legal = (size == sfd_pkg::SFD_SIZE_BYTE); // [R4]
      sfd_pkg::SFD_CLS_CMP16,
      sfd_pkg::SFD_CLS_RO16:
        legal = ((cls == sfd_pkg::SFD_CLS_CMP16) == wr_i) &&
                ((size == sfd_pkg::SFD_SIZE_BYTE) ||
                 (size == sfd_pkg::SFD_SIZE_WORD && short_i &&
                  !eff_addr[0])); // [R5] [R6] [R7] [R8] [R9] [R3]
      sfd_pkg::SFD_CLS_CMP8:
        legal = wr_i && size == sfd_pkg::SFD_SIZE_BYTE; // [R16]
      sfd_pkg::SFD_CLS_RO8:
        legal = !wr_i && size == sfd_pkg::SFD_SIZE_BYTE; // [R16]
      sfd_pkg::SFD_CLS_STATUS:
        legal = !wr_i && (size == sfd_pkg::SFD_SIZE_BIT ||
                          size == sfd_pkg::SFD_SIZE_BYTE); // [R15]
      default:
        legal = (size == sfd_pkg::SFD_SIZE_BIT ||
                 size == sfd_pkg::SFD_SIZE_BYTE); // [R19]
    endcase
  end

  assign do_write = req_i && wr_i && in_space && legal;

  // ---------------------------------------------------------------
  // read/write byte registers
  // ---------------------------------------------------------------
  // hardware interrupt events OR in after the write, so a set that
  // meets a software clear in the same cycle is kept
  genvar gi;
  for (gi = 0; gi < NUM_RW; gi++)
  begin : g_rw
    logic [7:0] wr_byte;
    logic [7:0] set_bits;

    assign rw_hit[gi] = (eff_addr == RW_ADDR[gi]);

    always_comb
    begin
      wr_byte = rw_r[gi];
      if (do_write && rw_hit[gi])
      begin
        if (size == sfd_pkg::SFD_SIZE_BIT)
          wr_byte[bit_sel_i] = wdata_i[0];
        else
          wr_byte = wdata_i[7:0];
      end
    end

    if (gi == `SFD_IDX_IRQ_FLAGS_0)
    begin : g_flags0
      assign set_bits = irq_set_i[7:0];
    end
    else if (gi == `SFD_IDX_IRQ_FLAGS_1)
    begin : g_flags1
      assign set_bits = irq_set_i[15:8];
    end
    else
    begin : g_plain
      assign set_bits = '0;
    end

    always_ff @(posedge clock_i)
    begin
      if (rst_i)
      begin
        rw_r[gi] <= RW_RESET[gi]; // [R17]
      end
      else
      begin
        rw_r[gi] <= wr_byte | set_bits; // [R11]
      end
    end

    assign rw_regs_o[gi*8 +: 8] = rw_r[gi];
  end

  // ---------------------------------------------------------------
  // write-only registers and their load strobes
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tx_shift_r <= `SFD_RST_SERIAL_SHIFT; // [R4] [R17]
      tx_load_o <= 1'h0;
    end
    else
    begin
      tx_load_o <= do_write && cls == sfd_pkg::SFD_CLS_SERIAL;
      if (do_write && cls == sfd_pkg::SFD_CLS_SERIAL)
        tx_shift_r <= wdata_i[7:0]; // [R4]
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      compare16_r <= `SFD_RST_COMPARE16; // [R5] [R17]
      compare16_wr_o <= 1'h0;
    end
    else
    begin
      compare16_wr_o <= do_write && cls == sfd_pkg::SFD_CLS_CMP16;
      if (do_write && cls == sfd_pkg::SFD_CLS_CMP16)
      begin
        if (size == sfd_pkg::SFD_SIZE_WORD)
          compare16_r <= wdata_i; // [R9]
        else if (eff_addr[0])
          compare16_r[15:8] <= wdata_i[7:0]; // [R8]
        else
          compare16_r[7:0] <= wdata_i[7:0]; // [R8]
      end
    end
  end

  // compare8 has no documented reset value; zero keeps it defined
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      compare8_r <= `SFD_RST_COMPARE8;
      compare8_wr_o <= 1'h0;
    end
    else
    begin
      compare8_wr_o <= do_write && cls == sfd_pkg::SFD_CLS_CMP8;
      if (do_write && cls == sfd_pkg::SFD_CLS_CMP8)
        compare8_r <= wdata_i[7:0]; // [R16]
    end
  end

  assign tx_shift_o = tx_shift_r;
  assign compare16_o = compare16_r;
  assign compare8_o = compare8_r;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // count and capture come from the timer on this clock, so a word
  // read samples both halves in the same cycle
  always_comb
  begin
    rd_byte = '0;
    rd_word = '0;
    for (int i = 0; i < NUM_RW; i++)
    begin
      if (rw_hit[i])
        rd_byte = rw_r[i];
    end
    case (cls)
      sfd_pkg::SFD_CLS_SERIAL:
        rd_byte = rx_buffer_i; // [R4]
      sfd_pkg::SFD_CLS_RO16:
      begin
        rd_word = (eff_addr[1]) ? capture16_i
                                : timer16_count_i; // [R6] [R7]
        rd_byte = (eff_addr[0]) ? rd_word[15:8] : rd_word[7:0];
      end
      sfd_pkg::SFD_CLS_RO8:
        rd_byte = timer8_count_i; // [R16]
      sfd_pkg::SFD_CLS_STATUS:
        rd_byte = async_status_i; // [R15]
      default:
        rd_word = '0; // [R19]
    endcase
  end

  always_comb
  begin
    rdata_nxt = '0;
    if (req_i && !wr_i && in_space && legal)
    begin
      case (size)
        sfd_pkg::SFD_SIZE_BIT:
          rdata_nxt = {15'h0000, rd_byte[bit_sel_i]};
        sfd_pkg::SFD_SIZE_WORD:
          rdata_nxt = rd_word;
        default:
          rdata_nxt = {8'h00, rd_byte};
      endcase
    end
  end

  // ---------------------------------------------------------------
  // answer to the core
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'h0;
      err_o <= 1'h0;
      rdata_o <= '0;
    end
    else
    begin
      ack_o <= req_i && in_space;
      err_o <= req_i && in_space && !legal; // [R2]
      rdata_o <= rdata_nxt;
    end
  end

endmodule

`default_nettype wire

// ### sfd_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// cpu core side: one request per access
// ----------------------------------------
module sfd_core_model (
  input wire logic clock_i,
  input wire logic ack_i,
  input wire logic err_i,
  input wire logic [15:0] rdata_i,
  output logic req_o,
  output logic wr_o,
  output logic short_o,
  output logic [1:0] size_o,
  output logic [2:0] bit_sel_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o
);
  logic got_ack, got_err;
  logic [15:0] got_data;

  initial
  begin
    req_o = 1'b0;
    wr_o = 1'b0;
    short_o = 1'b0;
    size_o = 2'h1;
    bit_sel_o = 3'h0;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
  end

  // short form carries the operand in the low address byte
  task automatic xfer(input logic w, s, input logic [1:0] z,
                      input logic [15:0] a, d, input logic [2:0] b);
    @(negedge clock_i);
    req_o = 1'b1;
    wr_o = w;
    short_o = s;
    size_o = z;
    addr_o = a;
    wdata_o = d;
    bit_sel_o = b;
    @(negedge clock_i);
    req_o = 1'b0;
    // released address and data lines do not keep the last value
    addr_o = ~a;
    wdata_o = ~d;
    got_ack = ack_i;
    got_err = err_i;
    got_data = rdata_i;
  endtask
endmodule

`default_nettype wire

// ### sfd_space_decode_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module sfd_space_decode_asserts (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic short_i,
  input wire logic [1:0] size_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [15:0] rdata_o,
  input wire logic [7:0] tx_shift_o,
  input wire logic tx_load_o,
  input wire logic [15:0] compare16_o,
  input wire logic [7:0] compare8_o,
  input wire logic compare8_wr_o
);
  logic in_page, byte_full;
  assign in_page = short_i ? (addr_i[7:0] < 8'h20) : (addr_i[15:8] == 8'hFF);
  assign byte_full = req_i && !short_i && size_i == 2'h1;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  chk_ack_on_page: assert property (req_i && in_page |=> ack_o)
    else $error("page request not answered");
  chk_off_page_quiet: assert property (req_i && !in_page |=> !ack_o)
    else $error("off page request answered");
  chk_err_has_ack: assert property (err_o |-> ack_o)
    else $error("refusal without answer");
  chk_word_long_err: assert property
    (req_i && in_page && size_i == 2'h3 && !short_i |=> ack_o && err_o)
    else $error("long form word access accepted");
  chk_word_odd_err: assert property
    (req_i && in_page && short_i && size_i == 2'h3 && addr_i[0] |=> err_o)
    else $error("odd word address accepted");
  chk_tx_load_value: assert property
    (byte_full && wr_i && addr_i == 16'hFF10 |=>
     tx_load_o && !err_o && tx_shift_o == $past(wdata_i[7:0]))
    else $error("transmit shift not loaded");
  chk_cmp8_write: assert property
    (byte_full && wr_i && addr_i == 16'hFF50 |=>
     compare8_wr_o && compare8_o == $past(wdata_i[7:0]))
    else $error("byte compare not loaded");
  chk_ro_write_err: assert property
    (byte_full && wr_i && addr_i[15:2] == 14'h3FC6 |=>
     err_o && rdata_o == 16'h0000)
    else $error("write to read-only timer accepted");
  chk_rdata_quiet: assert property (!ack_o |-> rdata_o == 16'h0000)
    else $error("read data without answer");
  chk_reset_loads: assert property
    ($fell(rst_i) |-> compare16_o == 16'hFFFF && tx_shift_o == 8'hFF)
    else $error("reset values not loaded");
endmodule

`default_nettype wire

// ### sfd_space_decode_tb.sv
`timescale 1ns/1ps
`include "sfd_regs.svh"
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s expected %h seen %h", n, e, g); end end

module sfd_space_decode_tb;
  localparam logic [1:0] BT = sfd_pkg::SFD_SIZE_BIT;
  localparam logic [1:0] BY = sfd_pkg::SFD_SIZE_BYTE;
  localparam logic [1:0] WD = sfd_pkg::SFD_SIZE_WORD;
  logic clock_i, rst_i, req, wr, sh, ack, err, txl, c16w, c8w;
  logic [1:0] sz;
  logic [2:0] bs;
  logic [7:0] rxb, t8, ast, txs, c8;
  logic [15:0] addr, wdata, t16, cap, irq, rdata, c16;
  logic [`SFD_NUM_RW*8-1:0] rw_regs;
  logic [15:0] ra [6] = '{16'hFF00, 16'hFF25, 16'hFFE1, 16'hFFE5,
                          16'hFFFA, 16'hFFFB};
  logic [15:0] rv [6] = '{16'h0000, 16'h00FF, 16'h0000, 16'h00FF,
                          16'h0004, 16'h0002};
  int num_errors = 0;
  int cmp_count = 0;

  sfd_space_decode sfd_space_decode_inst (.clock_i(clock_i), .rst_i(rst_i),
    .req_i(req), .wr_i(wr), .short_i(sh), .size_i(sz), .bit_sel_i(bs),
    .addr_i(addr), .wdata_i(wdata), .rx_buffer_i(rxb),
    .timer16_count_i(t16), .capture16_i(cap), .timer8_count_i(t8),
    .async_status_i(ast), .irq_set_i(irq), .ack_o(ack), .err_o(err),
    .rdata_o(rdata), .rw_regs_o(rw_regs), .tx_shift_o(txs),
    .tx_load_o(txl), .compare16_o(c16), .compare16_wr_o(c16w),
    .compare8_o(c8), .compare8_wr_o(c8w));

  sfd_core_model core_inst (.clock_i(clock_i), .ack_i(ack), .err_i(err),
    .rdata_i(rdata), .req_o(req), .wr_o(wr), .short_o(sh), .size_o(sz),
    .bit_sel_o(bs), .addr_o(addr), .wdata_o(wdata));

  // ----------------------------------------
  // shared access and verdict
  // ----------------------------------------
  task automatic op(input logic w, s, input logic [1:0] z,
                    input logic [15:0] a, d, input logic [2:0] b,
                    input logic ee, input logic [15:0] ed);
    core_inst.xfer(w, s, z, a, d, b);
    `CHK("ack", 1'b1, core_inst.got_ack)
    `CHK("err", ee, core_inst.got_err)
    // bit reads must return zeros above bit 0 as well
    `CHK("rdata", ed, core_inst.got_data)
  endtask

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_vals;
    for (int i = 0; i < 6; i++)
      op(0, 0, BY, ra[i], 16'h0, 3'h0, 0, rv[i]);
    `CHK("tx_shift", 8'hFF, txs)
    `CHK("compare16", 16'hFFFF, c16)
  endtask

  task automatic t_rw;
    op(1, 0, BY, 16'hFF20, 16'h005A, 3'h0, 0, 16'h0);
    `CHK("dir0", 8'h5A, rw_regs[55:48])
    op(1, 0, BT, 16'hFFE0, 16'h0001, 3'h3, 0, 16'h0);
    op(0, 0, BY, 16'hFFE0, 16'h0, 3'h0, 0, 16'h0008);
    op(1, 0, BT, 16'hFFE5, 16'h0000, 3'h0, 0, 16'h0);
    op(0, 0, BY, 16'hFFE5, 16'h0, 3'h0, 0, 16'h00FE);
    op(1, 1, BY, 16'h0003, 16'h0033, 3'h0, 0, 16'h0);
    op(0, 0, BY, 16'hFF03, 16'h0, 3'h0, 0, 16'h0033);
    irq = 16'h0100;
    @(negedge clock_i);
    irq = 16'h0000;
    op(0, 0, BY, 16'hFFE1, 16'h0, 3'h0, 0, 16'h0001);
  endtask

  task automatic t_width;
    op(1, 0, BT, 16'hFFFA, 16'h0001, 3'h0, 1, 16'h0);
    op(0, 0, BT, 16'hFFFB, 16'h0, 3'h1, 1, 16'h0);
    op(0, 0, WD, 16'hFFE0, 16'h0, 3'h0, 1, 16'h0);
    op(0, 0, 2'h2, 16'hFF00, 16'h0, 3'h0, 1, 16'h0);
    op(0, 0, BY, 16'hFFFA, 16'h0, 3'h0, 0, 16'h0004);
  endtask

  task automatic t_serial;
    op(1, 0, BY, 16'hFF10, 16'h00A5, 3'h0, 0, 16'h0);
    `CHK("tx_load", 1'b1, txl)
    `CHK("tx_shift", 8'hA5, txs)
    op(0, 0, BY, 16'hFF10, 16'h0, 3'h0, 0, 16'h003C);
  endtask

  task automatic t_timer16;
    op(0, 1, WD, 16'h0018, 16'h0, 3'h0, 0, 16'h1234);
    op(0, 0, WD, 16'hFF18, 16'h0, 3'h0, 1, 16'h0);
    op(0, 1, WD, 16'h0019, 16'h0, 3'h0, 1, 16'h0);
    op(1, 0, BY, 16'hFF18, 16'h0011, 3'h0, 1, 16'h0);
    op(0, 0, BY, 16'hFF1B, 16'h0, 3'h0, 0, 16'h00BE);
    op(0, 1, BY, 16'h001A, 16'h0, 3'h0, 0, 16'h00EF);
  endtask

  task automatic t_compare;
    op(1, 1, WD, 16'h0016, 16'hCAFE, 3'h0, 0, 16'h0);
    `CHK("compare16_wr", 1'b1, c16w)
    `CHK("compare16", 16'hCAFE, c16)
    op(1, 0, BY, 16'hFF17, 16'h0011, 3'h0, 0, 16'h0);
    `CHK("compare16", 16'h11FE, c16)
    op(0, 0, BY, 16'hFF16, 16'h0, 3'h0, 1, 16'h0);
    op(1, 0, BY, 16'hFF50, 16'h0077, 3'h0, 0, 16'h0);
    `CHK("compare8", 8'h77, c8)
    `CHK("compare8_wr", 1'b1, c8w)
    op(0, 0, BY, 16'hFF51, 16'h0, 3'h0, 0, 16'h009A);
    op(0, 0, BY, 16'hFF50, 16'h0, 3'h0, 1, 16'h0);
  endtask

  task automatic t_status_unmapped;
    op(0, 0, BT, 16'hFF71, 16'h0, 3'h2, 0, 16'h0001);
    op(0, 0, BY, 16'hFF71, 16'h0, 3'h0, 0, 16'h0044);
    op(1, 0, BY, 16'hFF71, 16'h0001, 3'h0, 1, 16'h0);
    op(0, 0, 2'h2, 16'hFF71, 16'h0, 3'h0, 1, 16'h0);
    op(1, 0, BY, 16'hFF30, 16'h0055, 3'h0, 0, 16'h0);
    op(0, 0, BY, 16'hFF30, 16'h0, 3'h0, 0, 16'h0);
    op(0, 0, 2'h2, 16'hFF30, 16'h0, 3'h0, 1, 16'h0);
    core_inst.xfer(0, 1, BY, 16'h0030, 16'h0, 3'h0);
    `CHK("ack", 1'b0, core_inst.got_ack)
    core_inst.xfer(0, 0, BY, 16'hFE00, 16'h0, 3'h0);
    `CHK("ack", 1'b0, core_inst.got_ack)
  endtask

  task automatic t_rereset;
    @(negedge clock_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    op(0, 0, BY, 16'hFF20, 16'h0, 3'h0, 0, 16'h00FF);
    `CHK("compare16", 16'hFFFF, c16)
  endtask

  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  initial
  begin
    #2000000;
    num_errors++;
    end_of_test();
  end

  initial
  begin
    rst_i = 1'b1;
    irq = 16'h0000;
    rxb = 8'h3C;
    t16 = 16'h1234;
    cap = 16'hBEEF;
    t8 = 8'h9A;
    ast = 8'h44;
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
    t_reset_vals();
    t_rw();
    t_width();
    t_serial();
    t_timer16();
    t_compare();
    t_status_unmapped();
    t_rereset();
    end_of_test();
  end
endmodule

bind sfd_space_decode sfd_space_decode_asserts chk_inst (
  .clock_i(clock_i), .rst_i(rst_i), .req_i(req_i), .wr_i(wr_i),
  .short_i(short_i), .size_i(size_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .ack_o(ack_o), .err_o(err_o), .rdata_o(rdata_o), .tx_shift_o(tx_shift_o),
  .tx_load_o(tx_load_o), .compare16_o(compare16_o),
  .compare8_o(compare8_o), .compare8_wr_o(compare8_wr_o));

`default_nettype wire
